// ===== logic/trig_pkg.sv
// Constants, register map and field layout of the trigger and input capture block.
// Assumes a 40 MHz core clock and a simple one-cycle register port.
package trig_pkg;
    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int NCH = 16;                   // Input channels
    localparam int CLK_PERIOD_NS = 25;         // Core clock period
    localparam int TICK_NS = 1000;             // Time base tick, 1 us
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam logic [5:0] US_LAST = 6'(TICK_CYCLES - 1);
    localparam int TMO_STEP_US = 2500;         // Timeout step, 2.5 ms
    localparam int SPACING_STEP_US = 100;      // Interrupt spacing step, 0.1 ms
    localparam logic [15:0] SP_STEP_TICKS = 16'(SPACING_STEP_US * 1000 / TICK_NS);
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [8:0] A_CTRL = 9'h000;    // Mode, gate, spacing
    localparam logic [8:0] A_ZERO = 9'h004;    // Zero transition, tooth widths
    localparam logic [8:0] A_TOOTH = 9'h008;   // Tooth width, half degrees
    localparam logic [8:0] A_RDELAY = 9'h00c;  // Request delay, us
    localparam logic [8:0] A_ANGLE = 9'h010;   // Angle count and window (read)
    localparam logic [8:0] A_POLL = 9'h014;    // Write: polled request
    localparam logic [8:0] A_VALID = 9'h018;   // Result held flags, write 1 clears
    localparam logic [8:0] A_ERR = 9'h01c;     // Timeout error flags, write 1 clears
    localparam logic [8:0] A_CFG = 9'h040;     // Per-channel configuration
    localparam logic [8:0] A_TMO = 9'h080;     // Per-channel timeout
    localparam logic [8:0] A_RESA = 9'h0c0;    // Per-channel result A
    localparam logic [8:0] A_RESB = 9'h100;    // Per-channel result B
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int CT_GATE = 2;
    localparam int CT_SP_LSB = 8;
    localparam int CT_SP_MSB = 15;
    localparam int CF_MODE_MSB = 2;
    localparam int CF_POL = 3;                 // 1: high level is active
    localparam int CF_EDGE_LSB = 4;
    localparam int CF_EDGE_MSB = 5;
    localparam int CF_HW = 6;                  // Use hardware trigger
    localparam int CF_IRQ = 7;                 // Interrupt delivery
    localparam int CF_HYST = 8;                // 1: user thresholds
    localparam int CF_LO_LSB = 16;
    localparam int CF_LO_MSB = 23;
    localparam int CF_HI_LSB = 24;
    localparam int CF_HI_MSB = 31;
    // ------------------------------------------------------------
    // Encodings and limits
    // ------------------------------------------------------------
    localparam logic [1:0] TM_OFF = 2'h0;
    localparam logic [1:0] TM_RISE = 2'h1;
    localparam logic [1:0] TM_STATE = 2'h2;
    localparam logic [1:0] TM_ANGLE = 2'h3;
    localparam logic [2:0] CM_OFF = 3'h0;
    localparam logic [2:0] CM_DIN = 3'h1;
    localparam logic [2:0] CM_PWM = 3'h2;
    localparam logic [2:0] CM_ADD = 3'h3;
    localparam logic [2:0] CM_CNT = 3'h4;
    localparam logic [1:0] SE_IA = 2'h0;
    localparam logic [1:0] SE_AI = 2'h1;
    localparam logic [7:0] TTL_LO = 8'h0c;     // 1.728 V in 0.144 V steps
    localparam logic [7:0] TTL_HI = 8'h10;     // 2.304 V in 0.144 V steps
    localparam logic [7:0] THR_MAX = 8'hfa;    // 36 V in 0.144 V steps
    localparam logic [14:0] ZERO_MIN = 15'h0002;
    localparam logic [10:0] TOOTH_MIN = 11'h001;
    localparam logic [10:0] TOOTH_MAX = 11'h5a0; // 720 degrees
    localparam logic [14:0] ZERO_RST = 15'h0002;
    localparam logic [10:0] TOOTH_RST = 11'h001;
endpackage

// ===== logic/trigger_gated_input_capture.sv
// Trigger unit and sixteen-channel digital input evaluation.
// Assumes trigger and channel inputs already synchronous to core_clk.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// How it works
// - Trigger mode off ignores both inputs
// - Rising edge on input one requests acquisition
// - Signal state: rise opens, fall closes window
// - Delayed request only if window still open
// - Angle counter: clear on rise, count falls
// - Gate on: edges count only while input two high
// - Gate off: every matching edge counts
// - Angle forces gate; gate frozen when off
// - Zero transition two to 32767 teeth
// - Tooth width 0.5 to 720 degrees
// - Minimum spacing between interrupts, 0.1 ms steps
// - Per-channel mode; digital input samples level
// - PWM reports last complete period
// - Additive time sums active phases
// - Event counter counts significant edges
// - Per-channel hardware trigger or polled requests
// - Interrupt after triggered acquisition, hardware only
// - Without interrupt, results held until the next capture
// - Polarity selects active level
// - Significant edge: rise, fall or both
// - Fixed logic thresholds or user thresholds
// - Timeout without change flags error
// - User thresholds 0.144 V steps, low below high
module trigger_gated_input_capture
    import trig_pkg::*;
#(
    parameter int unsigned TMO_STEP_TICKS = TMO_STEP_US * 1000 / TICK_NS // Ticks per timeout step
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic trig_in1,
    input wire logic trig_in2,
    input wire logic [NCH-1:0] din,
    output logic irq,
    output logic [NCH*8-1:0] thr_low,
    output logic [NCH*8-1:0] thr_high
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] us_cnt;              // Clock cycles within a 1 us tick
        logic [11:0] tmo_pre;            // Ticks within a timeout step
        logic [1:0] tmode;               // Trigger mode
        logic gate;                      // Trigger gate setting
        logic [7:0] spacing;             // Interrupt spacing, 0.1 ms units
        logic [14:0] zero;               // Zero transition, tooth widths
        logic [10:0] tooth;              // Tooth width, half degrees
        logic [15:0] rdelay;             // Request delay, us
        logic [14:0] angle;              // Tooth counter
        logic t1_prev;
        logic t2_prev;
        logic win;                       // Signal state window open
        logic dly_run;                   // Request delay running
        logic [15:0] dly_cnt;
        logic pend;                      // Interrupt waiting for spacing
        logic irq;
        logic [15:0] sp_cnt;             // Ticks left of spacing
        logic [NCH-1:0] valid;
        logic [NCH-1:0] err;
        logic [NCH-1:0] prev_act;
        logic [NCH-1:0][31:0] cfg;
        logic [NCH-1:0][15:0] tmo;
        logic [NCH-1:0][15:0] tcnt;      // Timeout steps since last change
        logic [NCH-1:0][15:0] act_cnt;   // Active time in running period
        logic [NCH-1:0][15:0] inact_cnt; // Inactive time in running period
        logic [NCH-1:0][15:0] last_act;
        logic [NCH-1:0][15:0] last_inact;
        logic [NCH-1:0][15:0] accum;     // Additive time or event count
        logic [NCH-1:0][15:0] res_a;
        logic [NCH-1:0][15:0] res_b;
        logic [31:0] rdata;
    } state_t;
    state_t q;
    state_t d;
    logic us_tick;   // One cycle per us
    logic tmo_tick;  // One cycle per timeout step
    logic t1_rise, t1_fall, t2_fall; // Trigger edges seen this cycle
    logic gate_eff;  // Gate after angle mode forcing
    logic gate_ok;   // Edge allowed by gate
    logic trig_req;  // Hardware acquisition request
    logic poll_req;  // Software acquisition request
    logic new_irq;   // Triggered capture wants an interrupt
    logic fire;      // Interrupt goes out now
    logic act, sig, req, en; // Loop temporaries for one channel
    logic [2:0] cmode; // Mode of the channel in the loop
    logic [3:0] idx; // Channel addressed by the register port

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Register group match by upper address bits
    function automatic logic in_grp(input logic [8:0] a, input logic [8:0] b);
        in_grp = (a[8:6] == b[8:6]);
    endfunction
    // Saturating increment, counters stick at full scale
    function automatic logic [15:0] sat16(input logic [15:0] v);
        sat16 = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction
    // Significant edge select
    function automatic logic sig_edge(input logic [1:0] e, input logic r, input logic f);
        case (e)
            SE_IA: sig_edge = r;
            SE_AI: sig_edge = f;
            default: sig_edge = r | f;
        endcase
    endfunction
    // Channel config as stored: thresholds made legal, interrupt only with hardware trigger
    function automatic logic [31:0] cfg_fix(input logic [31:0] w);
        logic [7:0] lo, hi;
        logic [31:0] c;
        lo = w[CF_LO_MSB:CF_LO_LSB];
        hi = w[CF_HI_MSB:CF_HI_LSB];
        if (!w[CF_HYST]) begin
            lo = TTL_LO;
            hi = TTL_HI;
        end else begin
            // Top code stays in range and leaves room for one step below it
            hi = (hi > THR_MAX) ? THR_MAX : ((hi == 8'h00) ? 8'h01 : hi);
            lo = (lo >= hi) ? hi - 8'h01 : lo;
        end
        c = {hi, lo, 7'h00, w[CF_HYST:0]};
        c[CF_IRQ] = w[CF_IRQ] & w[CF_HW];
        cfg_fix = c;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        act = 1'b0;
        sig = 1'b0;
        req = 1'b0;
        en = 1'b0;
        cmode = CM_OFF;
        new_irq = 1'b0;
        idx = reg_addr[5:2];
        // Time base
        us_tick = (q.us_cnt == US_LAST);
        d.us_cnt = us_tick ? 6'h00 : q.us_cnt + 6'h01;
        tmo_tick = us_tick && (q.tmo_pre == 12'(TMO_STEP_TICKS - 1));
        if (us_tick) begin
            d.tmo_pre = tmo_tick ? 12'h000 : q.tmo_pre + 12'h001;
        end
        // Trigger edges
        t1_rise = trig_in1 & ~q.t1_prev;
        t1_fall = ~trig_in1 & q.t1_prev;
        t2_fall = ~trig_in2 & q.t2_prev;
        d.t1_prev = trig_in1;
        d.t2_prev = trig_in2;
        gate_eff = (q.tmode == TM_ANGLE) | q.gate;
        gate_ok = ~gate_eff | trig_in2;
        trig_req = 1'b0;
        case (q.tmode)
            TM_RISE: begin
                trig_req = t1_rise & gate_ok;
            end
            TM_STATE: begin
                if (t1_fall) begin
                    // Window closes; a delay still running is dropped
                    d.win = 1'b0;
                    d.dly_run = 1'b0;
                end else if (t1_rise && gate_ok) begin
                    d.win = 1'b1;
                    d.dly_cnt = 16'h0000;
                    d.dly_run = (q.rdelay != 16'h0000);
                    trig_req = (q.rdelay == 16'h0000);
                end else if (q.dly_run && us_tick) begin
                    d.dly_cnt = q.dly_cnt + 16'h0001;
                    if (d.dly_cnt == q.rdelay) begin
                        d.dly_run = 1'b0;
                        trig_req = q.win;
                    end
                end
            end
            TM_ANGLE: begin
                if (t1_rise) begin
                    d.angle = 15'h0000;
                end else if (t2_fall) begin
                    // Wraps at the zero transition if the zero edge is missed
                    d.angle = (q.angle + 15'h0001 >= q.zero) ? 15'h0000 : q.angle + 15'h0001;
                end
                trig_req = t1_rise & gate_ok;
            end
            default: begin
                // Inputs ignored altogether
                d.win = 1'b0;
                d.dly_run = 1'b0;
            end
        endcase
        // Register writes
        poll_req = reg_wr && (reg_addr == A_POLL);
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: begin
                    d.tmode = reg_wdata[1:0];
                    d.spacing = reg_wdata[CT_SP_MSB:CT_SP_LSB];
                    if (q.tmode != TM_OFF) begin
                        d.gate = reg_wdata[CT_GATE];
                    end
                end
                A_ZERO: begin
                    d.zero = (reg_wdata[14:0] < ZERO_MIN) ? ZERO_MIN : reg_wdata[14:0];
                end
                A_TOOTH: begin
                    d.tooth = (reg_wdata[10:0] < TOOTH_MIN) ? TOOTH_MIN
                        : ((reg_wdata[10:0] > TOOTH_MAX) ? TOOTH_MAX : reg_wdata[10:0]);
                end
                A_RDELAY: d.rdelay = reg_wdata[15:0];
                A_VALID: d.valid = q.valid & ~reg_wdata[NCH-1:0];
                A_ERR: d.err = q.err & ~reg_wdata[NCH-1:0];
                default: begin
                    if (in_grp(reg_addr, A_CFG)) begin
                        d.cfg[idx] = cfg_fix(reg_wdata);
                    end else if (in_grp(reg_addr, A_TMO)) begin
                        d.tmo[idx] = reg_wdata[15:0];
                    end
                end
            endcase
        end
        // Channels; flag sets come after the clears so a set wins
        for (int i = 0; i < NCH; i++) begin
            cmode = q.cfg[i][CF_MODE_MSB:0];
            act = q.cfg[i][CF_POL] ? din[i] : ~din[i];
            sig = sig_edge(q.cfg[i][CF_EDGE_MSB:CF_EDGE_LSB], act & ~q.prev_act[i], ~act & q.prev_act[i]);
            en = !(q.cfg[i][CF_HW] && q.tmode == TM_STATE) || q.win;
            req = q.cfg[i][CF_HW] ? trig_req : poll_req;
            d.prev_act[i] = act;
            // Timeout watch
            if (cmode == CM_OFF || act != q.prev_act[i]) begin
                d.tcnt[i] = 16'h0000;
            end else if (tmo_tick) begin
                d.tcnt[i] = sat16(q.tcnt[i]);
            end
            if (cmode != CM_OFF && q.tmo[i] != 16'h0000 && q.tcnt[i] >= q.tmo[i]) begin
                d.err[i] = 1'b1;
            end
            // Phase timers and accumulation
            if (us_tick) begin
                if (act) begin
                    d.act_cnt[i] = sat16(q.act_cnt[i]);
                end else begin
                    d.inact_cnt[i] = sat16(q.inact_cnt[i]);
                end
                if (act && en && cmode == CM_ADD) begin
                    d.accum[i] = sat16(q.accum[i]);
                end
            end
            if (cmode == CM_PWM && sig) begin
                // Period boundary: keep the finished period
                d.last_act[i] = q.act_cnt[i];
                d.last_inact[i] = q.inact_cnt[i];
                d.act_cnt[i] = 16'h0000;
                d.inact_cnt[i] = 16'h0000;
            end
            if (cmode == CM_CNT && sig && en) begin
                d.accum[i] = sat16(q.accum[i]);
            end
            // Capture on request
            if (req && cmode != CM_OFF) begin
                case (cmode)
                    CM_DIN: begin
                        d.res_a[i] = {15'h0000, act};
                        d.res_b[i] = 16'h0000;
                    end
                    CM_PWM: begin
                        d.res_a[i] = d.last_act[i];
                        d.res_b[i] = d.last_inact[i];
                    end
                    default: begin
                        // Interval ends here; an edge in this very cycle still counts toward it
                        d.res_a[i] = d.accum[i];
                        d.res_b[i] = 16'h0000;
                        d.accum[i] = 16'h0000;
                    end
                endcase
                d.valid[i] = 1'b1;
                if (q.cfg[i][CF_HW] && q.cfg[i][CF_IRQ]) begin
                    new_irq = 1'b1;
                end
            end
        end
        // Interrupt spacing
        fire = q.pend && (q.sp_cnt == 16'h0000) && (q.tmode != TM_OFF);
        d.irq = fire;
        if (fire) begin
            d.sp_cnt = 16'(q.spacing) * SP_STEP_TICKS;
        end else if (us_tick && q.sp_cnt != 16'h0000) begin
            d.sp_cnt = q.sp_cnt - 16'h0001;
        end
        d.pend = (q.pend & ~fire) | new_irq;
        // Read port, data valid for one cycle
        d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                A_CTRL: d.rdata = {16'h0000, q.spacing, 5'h00, q.gate, q.tmode};
                A_ZERO: d.rdata = {17'h00000, q.zero};
                A_TOOTH: d.rdata = {21'h000000, q.tooth};
                A_RDELAY: d.rdata = {16'h0000, q.rdelay};
                A_ANGLE: d.rdata = {16'h0000, q.win, q.angle};
                A_VALID: d.rdata = {16'h0000, q.valid};
                A_ERR: d.rdata = {16'h0000, q.err};
                default: begin
                    if (in_grp(reg_addr, A_CFG)) begin
                        d.rdata = q.cfg[idx];
                    end else if (in_grp(reg_addr, A_TMO)) begin
                        d.rdata = {16'h0000, q.tmo[idx]};
                    end else if (in_grp(reg_addr, A_RESA)) begin
                        d.rdata = {16'h0000, q.res_a[idx]};
                    end else if (in_grp(reg_addr, A_RESB)) begin
                        d.rdata = {16'h0000, q.res_b[idx]};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset loads constants only; channel configs start off with logic thresholds
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
            q.zero <= ZERO_RST;
            q.tooth <= TOOTH_RST;
            for (int i = 0; i < NCH; i++) begin
                q.cfg[i] <= {TTL_HI, TTL_LO, 16'h0000};
            end
        end else begin
            q <= d;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = q.rdata;
    assign irq = q.irq;
    // Threshold codes for the comparator DACs
    for (genvar g = 0; g < NCH; g++) begin : g_thr
        assign thr_low[g*8 +: 8] = q.cfg[g][CF_LO_MSB:CF_LO_LSB];
        assign thr_high[g*8 +: 8] = q.cfg[g][CF_HI_MSB:CF_HI_LSB];
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_open;
        q.tmode == TM_STATE && t1_rise && gate_ok && !t1_fall;
    endsequence
    sequence s_poll3;
        reg_wr && reg_addr == A_POLL && !q.cfg[3][CF_HW] && q.cfg[3][CF_MODE_MSB:0] == CM_DIN;
    endsequence
    a_off_quiet: assert property (q.tmode == TM_OFF |-> !trig_req && !fire)
        else $error("request or interrupt while trigger off");
    a_rise_start: assert property (q.tmode == TM_RISE && t1_rise && (!q.gate || trig_in2) |-> trig_req)
        else $error("rising edge did not request");
    a_window_open: assert property (s_open |=> q.win)
        else $error("window not opened");
    a_window_close: assert property (q.tmode == TM_STATE && t1_fall |=> !q.win)
        else $error("window not closed");
    a_delay_window: assert property (q.tmode == TM_STATE && trig_req |-> q.win || t1_rise)
        else $error("delayed request outside window");
    a_angle_clear: assert property (q.tmode == TM_ANGLE && t1_rise |=> q.angle == 15'h0000)
        else $error("angle not cleared");
    a_gate_block: assert property (q.tmode != TM_STATE && gate_eff && !trig_in2 |-> !trig_req)
        else $error("request while gate low");
    a_irq_spacing: assert property (q.irq && q.sp_cnt != 16'h0000 |=> (!q.irq) [*8])
        else $error("interrupts too close");
    a_pend_held: assert property (q.pend && q.sp_cnt != 16'h0000 |=> q.pend)
        else $error("pending interrupt dropped");
    a_poll_level: assert property (s_poll3 |=> q.valid[3] && q.res_a[3][0] == $past(q.cfg[3][CF_POL] ~^ din[3]))
        else $error("digital level capture wrong");
    a_tmo_error: assert property (q.cfg[0][CF_MODE_MSB:0] != CM_OFF && q.tmo[0] != 16'h0000
        && q.tcnt[0] >= q.tmo[0] |=> q.err[0])
        else $error("timeout not flagged");
    a_irq_hw_only: assert property (!q.cfg[1][CF_HW] |-> !q.cfg[1][CF_IRQ])
        else $error("interrupt enabled without hardware trigger");
    a_thr_order: assert property (q.cfg[2][CF_LO_MSB:CF_LO_LSB] < q.cfg[2][CF_HI_MSB:CF_HI_LSB])
        else $error("low threshold not below high");
endmodule

// ===== verification/trig_source.sv
// Far-side model: trigger input sources for the capture block.
// Assumes bench commands change just after core_clk rising edges.
`timescale 1ns/100ps
module trig_source (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic teeth_on,
    input wire logic t1_cmd,
    input wire logic t2_cmd,
    output logic trig_in1,
    output logic trig_in2
);
    logic [2:0] ph_q; // Phase within one tooth
    logic [1:0] n_q; // Tooth index, four teeth per turn
    // Tooth position advances only while teeth run
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {n_q, ph_q} <= 5'h00;
        end else if (teeth_on) begin
            {n_q, ph_q} <= {n_q, ph_q} + 5'h01;
        end
    end
    // Equidistant teeth; zero edge rises with tooth high, falls while tooth low
    assign trig_in2 = teeth_on ? ~ph_q[2] : t2_cmd;
    assign trig_in1 = teeth_on ? (n_q == 2'h0 && ph_q != 3'h0 && ph_q < 3'h6) : t1_cmd;
endmodule

// ===== verification/trigger_gated_input_capture_bench.sv
// Self-checking bench for the trigger and input capture block.
// Assumes the trigger source model drives both trigger inputs.
`timescale 1ns/100ps
module trigger_gated_input_capture_bench;
    import trig_pkg::*;
    logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, t1 = 0, t2 = 0, teeth = 0;
    logic [8:0] reg_addr = 9'h000;
    logic [31:0] reg_wdata = 32'h0, rd;
    logic [15:0] din = 16'h0000;
    wire logic [31:0] reg_rdata;
    wire logic irq, trig_in1, trig_in2;
    wire logic [127:0] thr_low, thr_high;
    int err_total = 0, tests_run = 0, cyc = 0, at;
    always #12.5 core_clk = ~core_clk;
    // Short timeout step keeps error timing small
    trigger_gated_input_capture #(.TMO_STEP_TICKS(4)) trigger_gated_input_capture_inst (.core_clk(core_clk),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trig_in1(trig_in1), .trig_in2(trig_in2), .din(din), .irq(irq),
        .thr_low(thr_low), .thr_high(thr_high));
    trig_source trig_source_inst (.core_clk(core_clk), .rst(rst), .teeth_on(teeth), .t1_cmd(t1),
        .t2_cmd(t2), .trig_in1(trig_in1), .trig_in2(trig_in2));
    // Hang guard, well above the longest expected run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask
    task rdr(input logic [8:0] a);
        @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk) reg_rd <= 1'b0;
        @(negedge core_clk) rd = reg_rdata; // Data stands one cycle only
    endtask
    // Pulse trigger one for n cycles, note first irq cycle or -1
    task trig(input int n);
        at = -1;
        @(posedge core_clk) t1 <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            if (irq === 1'b1 && at < 0) at = i;
        end
        @(posedge core_clk) t1 <= 1'b0;
    endtask
    task summarize();
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_off();
        check(thr_low[7:0], {24'h0, TTL_LO});
        check(thr_high[127:120], {24'h0, TTL_HI});
        wr(A_CFG + 9'h008, 32'h1020_0100);
        @(negedge core_clk) check(thr_low[23:16], {24'h0, 8'h0f});
        check(thr_high[23:16], {24'h0, 8'h10});
        wr(A_CFG, 32'h0000_00c1);
        wr(A_CTRL, 32'h0000_0004);
        rdr(A_CTRL);
        check(rd[2], 1'b0);
        trig(10);
        check(at, -1);
    endtask
    task t_rise_gate();
        wr(A_CTRL, 32'h0000_0001);
        trig(10);
        check(at >= 0, 1'b1);
        rdr(A_RESA);
        check(rd[0], 1'b1);
        wr(A_CTRL, 32'h0000_0005);
        trig(10);
        check(at, -1);
        @(posedge core_clk) t2 <= 1'b1;
        trig(10);
        check(at >= 0, 1'b1);
        wr(A_CTRL, 32'h0000_0001);
        @(posedge core_clk) t2 <= 1'b0;
        trig(10);
        check(at >= 0, 1'b1);
    endtask
    task t_state();
        wr(A_RDELAY, 32'd5);
        wr(A_CTRL, 32'h0000_0002);
        trig(10);
        check(at, -1);
        trig(300);
        check(at > 160 && at < 205, 1'b1);
    endtask
    task t_poll();
        wr(A_CFG + 9'h004, 32'h0000_00ac);
        wr(A_CFG + 9'h00c, 32'h0000_0009);
        wr(A_POLL, 32'h0);
        @(posedge core_clk) din[3] <= 1'b1;
        repeat (3) begin
            @(posedge core_clk) din[1] <= ~din[1];
            repeat (3) @(posedge core_clk);
        end
        wr(A_POLL, 32'h0);
        rdr(A_RESA + 9'h004);
        check(rd[15:0], 16'h0003);
        rdr(A_RESA + 9'h00c);
        check(rd[0], 1'b1);
        rdr(A_VALID);
        check(rd[1], 1'b1);
        rdr(A_ERR);
        check(rd[0], 1'b0);
        wr(A_TMO, 32'h0000_0001);
        rdr(A_ERR);
        check(rd[0], 1'b1);
    endtask
    task t_space();
        wr(A_CTRL, 32'h0000_0101);
        trig(10);
        trig(4200);
        check(at > 3900 && at < 4050, 1'b1);
    endtask
    task t_angle();
        wr(A_ZERO, 32'd100);
        wr(A_CTRL, 32'h0000_0003);
        @(posedge core_clk) teeth <= 1'b1;
        do @(negedge core_clk);
        while (!(trig_source_inst.n_q == 2'h2 && trig_source_inst.ph_q == 3'h6));
        @(posedge core_clk) teeth <= 1'b0;
        rdr(A_ANGLE);
        check(rd[14:0], 15'h0003);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_off();
        t_rise_gate();
        t_state();
        t_poll();
        t_space();
        t_angle();
        summarize();
    end
endmodule
